// ===== core/pmws_pkg.sv
// Constants and types shared by the wake/status bit block
package pmws_pkg;

  // Register offsets, byte addresses inside the event block
  localparam logic [1:0] STATUS_OFFSET = 2'h0;
  localparam logic [1:0] ENABLE_OFFSET = 2'h2;

  // Field positions in the status and enable words
  localparam int unsigned PWR_BIT   = 8;
  localparam int unsigned SLP_BIT   = 9;
  localparam int unsigned ALARM_BIT = 10;
  localparam int unsigned WAKE_BIT  = 15;

  // Byte lane positions
  localparam int unsigned LANE_LO = 0;
  localparam int unsigned LANE_HI = 1;

  // Values after reset
  localparam logic        FLAG_RESET    = 1'b0;
  localparam logic        ALLOW_RESET   = 1'b0;
  localparam logic [15:0] RDATA_RESET   = 16'h0000;

  // Power-button override time and the clock that counts it
  localparam longint unsigned OVR_TIME_MS = 4000;
  localparam longint unsigned CLK_HZ      = 25000000;
  // More than four seconds: one cycle past the printed time
  localparam longint unsigned OVR_CYCLES_L = (OVR_TIME_MS * CLK_HZ) / 1000 + 1;
  localparam int unsigned     OVR_CNT_W    = 27;
  localparam logic [OVR_CNT_W-1:0] OVR_CYCLES = OVR_CYCLES_L[OVR_CNT_W-1:0];
  localparam logic [OVR_CNT_W-1:0] OVR_CNT_RESET = 27'h0000000;

  // Button and alarm synchroniser inputs: count, indices and reset value
  localparam int unsigned N_EVT   = 3;
  localparam int unsigned EVT_PWR = 0;
  localparam int unsigned EVT_SLP = 1;
  localparam int unsigned EVT_ALM = 2;
  localparam logic [N_EVT-1:0] SYNC_RESET = 3'h0;

  // System power state as seen by this block
  typedef enum logic [2:0] {
    PMWS_WORKING  = 3'b001,
    PMWS_SLEEPING = 3'b010,
    PMWS_SOFT_OFF = 3'b100
  } pmws_sys_state_t;

  // Override watcher states
  typedef enum logic [2:0] {
    OVR_IDLE  = 3'b001,
    OVR_COUNT = 3'b010,
    OVR_HELD  = 3'b100
  } pmws_ovr_state_t;

  // One I/O access from software
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [1:0]  addr;
    logic [1:0]  be;
    logic [15:0] wdata;
  } pmws_io_req_t;

  // The four hardware-set flags
  typedef struct packed {
    logic wake;
    logic alarm;
    logic sleep_button;
    logic power_button;
  } pmws_flags_t;

  localparam pmws_flags_t FLAGS_RESET = 4'h0;

endpackage

// ===== core/pmws_status_bits.sv
// Upper half of the power-management status register with its enable bits
`timescale 1ns/100ps
`default_nettype none

// Function
// R1 - Status bits 6-7 and 12-14 always read back as zero.
// R2 - Software ignores status bit 11; it reads zero here.
// R3 - Power-button flag, bit 8, set by hardware on every press.
// R4 - Working state: interrupt while power-button flag and its allow bit are set.
// R5 - Sleeping or soft-off: power-button press wakes regardless of allow bit.
// R6 - Button and alarm flags set by hardware, cleared only by writing one or, for the power button, by the override.
// R7 - Button held over four seconds clears its flag and forces soft-off.
// R8 - Power-button wake leaves its flag set before software runs.
// R9 - Sleep-button flag, bit 9, set by hardware on every press.
// R10 - Working state: interrupt while sleep-button flag and its allow bit are set.
// R11 - Sleeping or soft-off: sleep-button press wakes only when allowed.
// R12 - Sleep-button wake leaves its flag set before software runs.
// R13 - Alarm flag, bit 10, set when the clock raises its alarm request.
// R14 - Alarm flag with allow bit set produces a power management event.
// R15 - Alarm wake sets flag first; from S4 only with deep-wake support.
// R16 - Wake flag, bit 15, set when sleeping and an enabled wake occurs.
// R17 - Setting the wake flag returns the system to the working state.
// R18 - Wake flag set only by hardware, cleared only by writing one.
// R19 - Software ignores button flags of absent or separately described buttons.
// R20 - Allow bits sit at 8, 9, 10 of the enable word, half-block above.
// R21 - Status register reached by byte or word I/O accesses.
// R22 - One control-interrupt output, OR of all working-state interrupt conditions.
// R23 - Button inputs synchronised and edge-detected; one press sets once.
module pmws_status_bits
  import pmws_pkg::*;
#(
  parameter logic [OVR_CNT_W-1:0] OVR_LIMIT = OVR_CYCLES
)
(
  // Clock, reset, clock enable
  input  wire logic            ref_clk,
  input  wire logic            nrst,
  input  wire logic            clk_en,

  // Software I/O access
  input  wire pmws_io_req_t    io_req,
  output logic [15:0]          io_rdata,
  output logic                 io_rack,

  // Buttons and alarm request
  input  wire logic            power_button_in,
  input  wire logic            sleep_button_in,
  input  wire logic            alarm_irq_in,

  // System state and platform flags
  input  wire pmws_sys_state_t sys_state,
  input  wire logic            sleep_is_s4,
  input  wire logic            alarm_deep_wake_support,

  // Events toward the rest of the system
  output logic                 control_interrupt,
  output logic                 wake_to_working,
  output logic                 soft_off_request
);

  // Synchroniser stages and previous value for edge detection
  logic [N_EVT-1:0]     sync1_ff;
  logic [N_EVT-1:0]     sync2_ff;
  logic [N_EVT-1:0]     prev_ff;
  logic [N_EVT-1:0]     raw_in;
  logic [N_EVT-1:0]     rise;

  // Stored flags and allow bits
  pmws_flags_t          flags_ff;
  pmws_flags_t          nxt_flags;
  logic                 power_button_irq_allow_ff;
  logic                 sleep_button_irq_allow_ff;
  logic                 alarm_irq_allow_ff;

  // Override watcher
  pmws_ovr_state_t      ovr_state_ff;
  pmws_ovr_state_t      nxt_ovr_state;
  logic [OVR_CNT_W-1:0] ovr_cnt_ff;
  logic                 ovr_fire;

  // Registered outputs
  logic [15:0]          rdata_ff;
  logic                 rack_ff;
  logic                 ctl_irq_ff;
  logic                 wake_pulse_ff;
  logic                 soft_off_ff;

  // Decoded accesses and events
  logic                 wr_status;
  logic                 wr_enable;
  logic                 hit_status;
  logic                 hit_enable;
  logic [15:0]          clr_mask;
  logic                 asleep;
  logic                 wake_evt;
  logic                 alarm_wake_ok;
  logic [15:0]          status_word;
  logic [15:0]          enable_word;

  assign raw_in[EVT_PWR] = power_button_in;
  assign raw_in[EVT_SLP] = sleep_button_in;
  assign raw_in[EVT_ALM] = alarm_irq_in;

  // Two-stage synchroniser and edge detector per event input
  genvar gi;
  generate
    for (gi = 0; gi < N_EVT; gi++)
    begin : g_sync
      always_ff @(posedge ref_clk or negedge nrst)
      begin
        if (!nrst)
        begin
          sync1_ff[gi] <= SYNC_RESET[gi];
          sync2_ff[gi] <= SYNC_RESET[gi];
          prev_ff[gi]  <= SYNC_RESET[gi];
        end
        else if (clk_en)
        begin
          sync1_ff[gi] <= raw_in[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          prev_ff[gi]  <= sync2_ff[gi];
        end
      end
      // A held button gives one rising edge, so one flag setting per press
      assign rise[gi] = sync2_ff[gi] & ~prev_ff[gi]; // R23
    end
  endgenerate

  // Address decode; odd addresses are unmapped and read as zero
  assign hit_status = (io_req.addr == STATUS_OFFSET); // R21
  assign hit_enable = (io_req.addr == ENABLE_OFFSET); // R20
  assign wr_status  = io_req.wr & hit_status;
  assign wr_enable  = io_req.wr & hit_enable;

  // Only the upper lane holds bits here; lower lane writes are harmless
  assign clr_mask = wr_status && io_req.be[LANE_HI] ?
                    {io_req.wdata[15:8], 8'h00} : 16'h0000; // R21

  assign asleep = (sys_state != PMWS_WORKING);

  // Alarm may wake from S4 only when the platform supports it
  assign alarm_wake_ok = !sleep_is_s4 || alarm_deep_wake_support; // R15

  // Enabled wake sources while asleep
  assign wake_evt = asleep &&
                    (rise[EVT_PWR] ||                                // R5
                     (rise[EVT_SLP] && sleep_button_irq_allow_ff) || // R11
                     (rise[EVT_ALM] && alarm_irq_allow_ff && alarm_wake_ok)); // R14

  assign ovr_fire = (ovr_state_ff == OVR_COUNT) && (ovr_cnt_ff >= OVR_LIMIT);

  // Flag update: a set in the same cycle as a write clear wins
  always_comb
  begin
    nxt_flags = flags_ff;
    // Power button: override clear beats both press and write
    if (ovr_fire)
      nxt_flags.power_button = 1'b0; // R7
    else
      nxt_flags.power_button = (flags_ff.power_button & ~clr_mask[PWR_BIT])
                               | rise[EVT_PWR]; // R3 R6 R8
    nxt_flags.sleep_button = (flags_ff.sleep_button & ~clr_mask[SLP_BIT])
                             | rise[EVT_SLP]; // R9 R6 R12
    nxt_flags.alarm = (flags_ff.alarm & ~clr_mask[ALARM_BIT])
                      | rise[EVT_ALM]; // R13 R6 R15
    nxt_flags.wake = (flags_ff.wake & ~clr_mask[WAKE_BIT])
                     | wake_evt; // R16 R18
  end

  // Flags register
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      flags_ff <= FLAGS_RESET;
    else if (clk_en)
      flags_ff <= nxt_flags;
  end

  // Allow bits, written through the upper lane of the enable word
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      power_button_irq_allow_ff <= ALLOW_RESET;
      sleep_button_irq_allow_ff <= ALLOW_RESET;
      alarm_irq_allow_ff        <= ALLOW_RESET;
    end
    else if (clk_en && wr_enable && io_req.be[LANE_HI])
    begin
      power_button_irq_allow_ff <= io_req.wdata[PWR_BIT];   // R20
      sleep_button_irq_allow_ff <= io_req.wdata[SLP_BIT];   // R20
      alarm_irq_allow_ff        <= io_req.wdata[ALARM_BIT]; // R20
    end
  end

  // Next override state: count while the synchronised button stays down
  always_comb
  begin
    nxt_ovr_state = ovr_state_ff;
    unique case (ovr_state_ff)
      OVR_IDLE:
        if (rise[EVT_PWR])
          nxt_ovr_state = OVR_COUNT;
      OVR_COUNT:
        if (!sync2_ff[EVT_PWR])
          nxt_ovr_state = OVR_IDLE;
        else if (ovr_fire)
          nxt_ovr_state = OVR_HELD; // R7
      OVR_HELD:
        if (!sync2_ff[EVT_PWR])
          nxt_ovr_state = OVR_IDLE;
      default:
        nxt_ovr_state = OVR_IDLE;
    endcase
  end

  // Override state and its counter
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ovr_state_ff <= OVR_IDLE;
      ovr_cnt_ff   <= OVR_CNT_RESET;
    end
    else if (clk_en)
    begin
      ovr_state_ff <= nxt_ovr_state;
      // Counter rests at zero outside a count so each press starts fresh
      if (nxt_ovr_state == OVR_COUNT)
        ovr_cnt_ff <= ovr_cnt_ff + 27'h0000001;
      else
        ovr_cnt_ff <= OVR_CNT_RESET;
    end
  end

  // Soft-off request pulses once; HELD stops a repeat while still pressed
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      soft_off_ff <= 1'b0;
    else if (clk_en)
      soft_off_ff <= ovr_fire; // R7
  end

  // Wake pulse on the cycle the wake flag first sets
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      wake_pulse_ff <= 1'b0;
    else if (clk_en)
      wake_pulse_ff <= nxt_flags.wake & ~flags_ff.wake; // R17
  end

  // Control interrupt is a level, held in the working state while any flag and allow pair holds
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      ctl_irq_ff <= 1'b0;
    else if (clk_en)
      ctl_irq_ff <= (sys_state == PMWS_WORKING) &&
                    ((nxt_flags.power_button && power_button_irq_allow_ff) || // R4
                     (nxt_flags.sleep_button && sleep_button_irq_allow_ff) || // R10
                     (nxt_flags.alarm && alarm_irq_allow_ff)); // R14 R22
  end

  // Readable words; unlisted bits, bit 11 and reserved bits are zero
  always_comb
  begin
    status_word            = 16'h0000; // R1 R2
    status_word[PWR_BIT]   = flags_ff.power_button;
    status_word[SLP_BIT]   = flags_ff.sleep_button;
    status_word[ALARM_BIT] = flags_ff.alarm;
    status_word[WAKE_BIT]  = flags_ff.wake;
    enable_word            = 16'h0000;
    enable_word[PWR_BIT]   = power_button_irq_allow_ff;
    enable_word[SLP_BIT]   = sleep_button_irq_allow_ff;
    enable_word[ALARM_BIT] = alarm_irq_allow_ff;
  end

  // Read data, one cycle after the strobe; lanes not enabled read zero
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff <= RDATA_RESET;
      rack_ff  <= 1'b0;
    end
    else if (clk_en)
    begin
      rack_ff <= io_req.rd;
      if (io_req.rd)
      begin
        if (hit_status)
          rdata_ff <= status_word & {{8{io_req.be[LANE_HI]}}, {8{io_req.be[LANE_LO]}}}; // R21
        else if (hit_enable)
          rdata_ff <= enable_word & {{8{io_req.be[LANE_HI]}}, {8{io_req.be[LANE_LO]}}};
        else
          rdata_ff <= RDATA_RESET;
      end
    end
  end

  // Outputs straight from flip-flops
  assign io_rdata          = rdata_ff;
  assign io_rack           = rack_ff;
  assign control_interrupt = ctl_irq_ff;
  assign wake_to_working   = wake_pulse_ff;
  assign soft_off_request  = soft_off_ff;

endmodule

`default_nettype wire

// ===== sim/pmws_chk.sv
// Port-level assertions for the wake/status bit block
`timescale 1ns/100ps
`default_nettype none
module pmws_chk
  import pmws_pkg::*;
#(
  parameter logic [OVR_CNT_W-1:0] OVR_LIMIT = OVR_CYCLES
)
(
  // Clock and reset
  input wire logic            ref_clk,
  input wire logic            nrst,
  input wire logic            clk_en,
  // Register access
  input wire pmws_io_req_t    io_req,
  input wire logic [15:0]     io_rdata,
  input wire logic            io_rack,
  // Event sources and state
  input wire logic            power_button_in,
  input wire logic            sleep_button_in,
  input wire logic            alarm_irq_in,
  input wire pmws_sys_state_t sys_state,
  input wire logic            sleep_is_s4,
  input wire logic            alarm_deep_wake_support,
  // Event outputs
  input wire logic            control_interrupt,
  input wire logic            wake_to_working,
  input wire logic            soft_off_request
);
  int   hold_ff;
  logic off_ff;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  // Length of the current power-button hold, raw pin cycles
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      hold_ff <= 0;
    else
      hold_ff <= power_button_in ? hold_ff + 1 : 0;
  end

  // Soft-off seen within this hold; a release forgets it
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      off_ff <= 1'b0;
    else
      off_ff <= power_button_in && (off_ff || soft_off_request);
  end

  a_rack_follows: assert property (io_req.rd && clk_en |=> io_rack)
    else $error("read not acknowledged");
  a_rack_cause: assert property (io_rack |-> $past(io_req.rd && clk_en))
    else $error("acknowledge without read");
  a_rsvd_zero: assert property (io_rack |->
    io_rdata[7:0] == 8'h00 && io_rdata[14:11] == 4'h0)
    else $error("reserved bits not zero");
  a_rdata_hold: assert property (!$past(io_req.rd && clk_en) |-> $stable(io_rdata))
    else $error("read data moved without read");
  a_irq_working: assert property (control_interrupt |->
    $past(sys_state) == PMWS_WORKING)
    else $error("interrupt outside working state");
  a_wake_single: assert property (wake_to_working |=> !wake_to_working)
    else $error("wake pulse too long");
  a_off_single: assert property (soft_off_request |=> !soft_off_request)
    else $error("soft-off pulse too long");
  // Pulse trails the pin by three edges; the button may already be released
  a_ovr_not_early: assert property (soft_off_request |-> $past(hold_ff, 3) >= OVR_LIMIT)
    else $error("soft-off before hold time");
  a_ovr_in_time: assert property (power_button_in && hold_ff == OVR_LIMIT + 8 |-> off_ff)
    else $error("soft-off missing after long hold");

  // Main scenarios reached
  cover property (wake_to_working);
  cover property (soft_off_request);
  cover property (control_interrupt);
  cover property (io_rack);
endmodule
bind pmws_status_bits pmws_chk #(.OVR_LIMIT(OVR_LIMIT)) chk_u (.ref_clk(ref_clk), .nrst(nrst),
  .clk_en(clk_en), .io_req(io_req), .io_rdata(io_rdata), .io_rack(io_rack),
  .power_button_in(power_button_in), .sleep_button_in(sleep_button_in),
  .alarm_irq_in(alarm_irq_in), .sys_state(sys_state), .sleep_is_s4(sleep_is_s4),
  .alarm_deep_wake_support(alarm_deep_wake_support), .control_interrupt(control_interrupt),
  .wake_to_working(wake_to_working), .soft_off_request(soft_off_request));
`default_nettype wire

// ===== sim/pmws_far_end.sv
// Buttons and alarm clock: each line held high for a requested count
`timescale 1ns/100ps
`default_nettype none
module pmws_far_end
(
  // Clock
  input wire logic        ref_clk,
  // Requests from the bench
  input wire logic [2:0]  start,
  input wire logic [7:0]  len,
  // Power, sleep, alarm lines
  output var logic [2:0]  lines
);
  int cnt [3] = '{0, 0, 0};

  // Requests taken on the rising edge, lines moved on the falling one
  always @(posedge ref_clk)
  begin
    for (int i = 0; i < 3; i++)
      cnt[i] <= start[i] ? int'(len) : (cnt[i] > 0 ? cnt[i] - 1 : 0);
  end

  // Lines go low when the hold runs out, as a released button does
  initial lines = 3'h0;
  always @(negedge ref_clk)
  begin
    for (int i = 0; i < 3; i++)
      lines[i] <= cnt[i] > 0;
  end
endmodule
`default_nettype wire

// ===== sim/pmws_status_bits_tb.sv
// Self-checking bench for the wake/status bit block
`timescale 1ns/100ps
`default_nettype none
module pmws_status_bits_tb
  import pmws_pkg::*;
;
  localparam logic [OVR_CNT_W-1:0] LIM = 27'h0000014;
  logic            ref_clk = 1'b0;
  logic            nrst = 1'b0;
  logic            clk_en = 1'b1;
  pmws_io_req_t    req = '0;
  pmws_sys_state_t st = PMWS_WORKING;
  logic            s4 = 1'b0;
  logic            deep = 1'b0;
  logic [2:0]      start = 3'h0;
  logic [7:0]      len = 8'h02;
  logic [2:0]      lines;
  logic [15:0]     rdata;
  logic [15:0]     w;
  logic            rack, ci, wake, off;
  int              fail_count = 0, n_checks = 0, seed = 8, cyc = 0;
  int              wakes = 0, offs = 0, f = 0, en = 0, ew = 0, eo = 0;

  always #20 ref_clk = ~ref_clk;

  // Pulse counts and the hang limit
  always @(posedge ref_clk)
  begin
    cyc++;
    if (nrst)
    begin
      wakes += int'(wake);
      offs += int'(off);
    end
    if (cyc == 20000)
    begin
      fail_count++;
      summarize();
    end
  end

  pmws_status_bits #(.OVR_LIMIT(LIM)) dut_u (.ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .io_req(req), .io_rdata(rdata), .io_rack(rack), .power_button_in(lines[0]),
    .sleep_button_in(lines[1]), .alarm_irq_in(lines[2]), .sys_state(st), .sleep_is_s4(s4),
    .alarm_deep_wake_support(deep), .control_interrupt(ci), .wake_to_working(wake),
    .soft_off_request(off));
  pmws_far_end far_u (.ref_clk(ref_clk), .start(start), .len(len), .lines(lines));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Model view of a register; unmapped places read zero
  // Bit 11 carries no meaning, and both buttons count as present here
  function automatic logic [15:0] mdl(input logic [1:0] a);
    if (a == STATUS_OFFSET)
      return 16'(f & 16'h8700);
    return a == ENABLE_OFFSET ? 16'(en & 16'h0700) : 16'h0;
  endfunction

  // One access held for one cycle; a frozen clock enable leaves the model alone
  task automatic io(input logic r, input logic [1:0] a, input logic [1:0] be,
                    input logic [15:0] d);
    @(negedge ref_clk);
    req = '{r, !r, a, be, d};
    @(negedge ref_clk);
    req = '0;
    if (r)
    begin
      chk({15'h0, rack}, 16'h0001);
      chk(rdata, be[1] ? mdl(a) : 16'h0);
    end
    else if (be[1] && clk_en)
    begin
      if (a == STATUS_OFFSET)
        f &= ~int'(d);
      else if (a == ENABLE_OFFSET)
        en = d & 16'h0700;
    end
  endtask

  // Press one line and predict flags, wake and soft-off
  task automatic press(input int i, input logic [7:0] n);
    int b;
    b = 'h100 << i;
    @(negedge ref_clk);
    len = n;
    start[i] = 1'b1;
    @(negedge ref_clk);
    start = 3'h0;
    repeat (n + 6) @(negedge ref_clk);
    f |= b;
    if (st != PMWS_WORKING && (i == 0 || (en & b) != 0) && !(i == 2 && s4 && !deep))
    begin
      f |= 'h8000;
      ew++;
    end
    // A hold of exactly the limit already fires the override
    if (i == 0 && n >= LIM)
    begin
      f &= ~b;
      eo++;
    end
    chk(16'(wakes), 16'(ew));
    chk(16'(offs), 16'(eo));
    chk({15'h0, ci}, {15'h0, st == PMWS_WORKING && (f & en) != 0});
  endtask

  task automatic summarize();
    $display("checks=%0d failures=%0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    io(1, 2'h0, 2'h3, 16'h0);
    io(1, 2'h2, 2'h3, 16'h0);
    io(1, 2'h1, 2'h3, 16'h0);
    io(0, 2'h2, 2'h3, 16'hffff);
    io(1, 2'h2, 2'h3, 16'h0);
    press(0, 8'h02);
    io(0, 2'h0, 2'h3, 16'h0000);
    io(1, 2'h0, 2'h3, 16'h0);
    io(0, 2'h0, 2'h2, 16'h0100);
    io(1, 2'h0, 2'h2, 16'h0);
    press(1, 8'h02);
    press(2, 8'h02);
    io(1, 2'h0, 2'h3, 16'h0);
    io(0, 2'h0, 2'h3, 16'hffff);
    io(0, 2'h2, 2'h3, 16'h0);
    press(0, 8'h02);
    clk_en = 1'b0;
    io(0, 2'h2, 2'h3, 16'hffff);
    clk_en = 1'b1;
    io(1, 2'h2, 2'h3, 16'h0);
    io(0, 2'h0, 2'h3, 16'hffff);
    st = PMWS_SLEEPING;
    press(1, 8'h02);
    press(0, 8'h02);
    io(1, 2'h0, 2'h3, 16'h0);
    io(0, 2'h0, 2'h3, 16'hffff);
    io(1, 2'h0, 2'h3, 16'h0);
    io(0, 2'h2, 2'h3, 16'h0400);
    s4 = 1'b1;
    press(2, 8'h02);
    deep = 1'b1;
    press(2, 8'h02);
    io(1, 2'h0, 2'h3, 16'h0);
    io(0, 2'h0, 2'h3, 16'hffff);
    st = PMWS_SOFT_OFF;
    press(0, 8'h02);
    io(0, 2'h0, 2'h3, 16'hffff);
    st = PMWS_WORKING;
    press(0, 8'h28);
    press(0, 8'(LIM));
    press(0, 8'(LIM - 27'h0000001));
    io(1, 2'h0, 2'h3, 16'h0);
    repeat (8)
    begin
      w = 16'($random(seed));
      io(0, {w[3], 1'b0}, w[1:0], w);
      io(1, 2'h0, 2'h3, 16'h0);
      io(1, 2'h2, 2'h3, 16'h0);
    end
    summarize();
  end
endmodule
`default_nettype wire
